// ==== bench/asp_spi_master.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Behavioural SPI master facing the sensor's serial pins
// ----------------------------------------------------------------------
module asp_spi_master (
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out,
  input  wire logic miso_in,
  input  wire logic miso_oe_in
);
  localparam time HALF_NS = 32;  // 64 ns link period stays under the rate ceiling.
  localparam time IDLE_NS = 750; // The register_idle_gap follows every frame.

  logic line;

  // The released data line is held low by the device's pull-down.
  assign line = miso_oe_in ? miso_in : 1'b0;

  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // The link clock stands still between frames, at the idle level of the mode.
  task automatic frame(input logic mode3, input logic [15:0] tx, input int nclk,
                       output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    sclk_out <= mode3;
    #(HALF_NS);
    cs_n_out <= 1'b0;
    #(3 * HALF_NS);
    for (i = 0; i < nclk; i++) begin
      sclk_out <= 1'b0;
      mosi_out <= tx[15-i];
      #(HALF_NS);
      rx[15-i] = line;
      sclk_out <= 1'b1;
      #(HALF_NS);
    end
    sclk_out <= mode3;
    mosi_out <= 1'b0;
    #(HALF_NS);
    cs_n_out <= 1'b1;
    #(IDLE_NS);
  endtask
endmodule

// ==== bench/test_angle_sensor_spi_slave.sv ====
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
  begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp); end end

module test_angle_sensor_spi_slave;
  localparam int MEM_WAIT = 600;

  logic        clk_in;
  logic        nrst_in;
  logic [15:0] angle_raw;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic        miso_oe;
  logic        rot_ccw;
  logic        nvm_busy;
  logic [15:0] rx;
  int          err_total;
  int          num_checks;

  asp_spi_slave #(.ANGLE_BITS(8), .MEM_WAIT_CYC(MEM_WAIT)) u_dut (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .sclk_in      (sclk),
    .cs_n_in      (cs_n),
    .mosi_in      (mosi),
    .angle_raw_in (angle_raw),
    .miso_out     (miso),
    .miso_oe_out  (miso_oe),
    .rot_ccw_out  (rot_ccw),
    .nvm_busy_out (nvm_busy)
  );

  asp_spi_master u_mst (
    .sclk_out   (sclk),
    .cs_n_out   (cs_n),
    .mosi_out   (mosi),
    .miso_in    (miso),
    .miso_oe_in (miso_oe)
  );

  initial clk_in = 1'b0;
  always #2.5 clk_in = ~clk_in;

  // ----------------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  function automatic logic [15:0] exp_angle(logic [15:0] raw, logic [15:0] z, logic ccw);
    logic [15:0] v;
    v = raw + z;
    if (ccw) begin
      v = -v;
    end
    return v & 16'hff00;
  endfunction

  task automatic xfer(input logic mode3, input logic [15:0] tx, input int n,
                      input logic [15:0] exp, input string msg);
    u_mst.frame(mode3, tx, n, rx);
    `CHK(rx, exp, msg)
  endtask

  // A request frame's own reply is an angle, which these callers do not judge.
  task automatic send(input logic [15:0] tx);
    u_mst.frame(1'b0, tx, 16, rx);
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 2000 && nvm_busy !== 1'b0; i++) begin
      @(posedge clk_in);
    end
    if (nvm_busy !== 1'b0) begin
      err_total++;
      $display("[FAIL] %0t memory update never finished", $time);
      end_of_test();
    end
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    `CHK(rot_ccw, 1'b0, "direction after power-up")
    `CHK(nvm_busy, 1'b0, "busy after power-up")
    `CHK(miso_oe, 1'b0, "output driven while idle")
    send({3'b010, 5'h06, 8'h00});
    xfer(1'b0, 16'h0000, 16, 16'h1c00, "factory word 6");
  endtask

  task automatic t_angle();
    int m;
    @(posedge clk_in);
    angle_raw <= 16'h1234;
    repeat (300) @(posedge clk_in);
    for (m = 0; m < 2; m++) begin
      xfer(m[0], 16'h0000, 16, 16'h1200, "angle in mode");
      `CHK(miso_oe, 1'b0, "output released after frame")
    end
    xfer(1'b0, 16'h0000, 5, 16'h1000, "partial angle");
    xfer(1'b1, 16'h0000, 16, 16'h1200, "repeated angle");
  endtask

  // The raw angle moves in mid-frame; the frozen buffer must not follow it.
  task automatic t_freeze();
    fork
      u_mst.frame(1'b0, 16'h0000, 16, rx);
      begin
        repeat (60) @(posedge clk_in);
        angle_raw <= 16'h5678;
      end
    join
    `CHK(rx, 16'h1200, "buffer frozen in frame")
    repeat (250) @(posedge clk_in);
    xfer(1'b0, 16'h0000, 16, 16'h5600, "buffer released");
  endtask

  task automatic t_read_order();
    send({3'b010, 5'h06, 8'h00});
    xfer(1'b1, 16'h0000, 16, 16'h1c00, "read reply at once");
    xfer(1'b0, 16'h0000, 16, 16'h5600, "angle after reply");
    send({3'b111, 5'h06, 8'h00});
    xfer(1'b0, 16'h0000, 16, 16'h5600, "unknown command");
  endtask

  task automatic t_write();
    send({3'b100, 5'h09, 8'h80});
    `CHK(nvm_busy, 1'b1, "memory update pending")
    xfer(1'b0, 16'h0000, 16, 16'h0000, "early reply old value");
    wait_idle();
    `CHK(rot_ccw, 1'b1, "direction after commit")
    send({3'b100, 5'h00, 8'h11});
    wait_idle();
    xfer(1'b1, 16'h0000, 16, 16'h1100, "write acknowledge");
    repeat (250) @(posedge clk_in);
    xfer(1'b0, 16'h0000, 16, exp_angle(16'h5678, 16'h0011, 1'b1), "ccw angle");
  endtask

  // A second power-up must bring back the stored words, not the factory ones.
  task automatic t_power();
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    `CHK(rot_ccw, 1'b1, "direction reloaded")
    send({3'b010, 5'h00, 8'h00});
    xfer(1'b0, 16'h0000, 16, 16'h1100, "word 0 reloaded");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    err_total = 0;
    num_checks = 0;
    nrst_in = 1'b0;
    angle_raw = 16'h0000;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    t_reset();
    t_angle();
    t_freeze();
    t_read_order();
    t_write();
    t_power();
    end_of_test();
  end
endmodule

// ==== rtl/asp_defs.svh ====
`ifndef ASP_DEFS_SVH
`define ASP_DEFS_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define ASP_FRAME_BITS    16
`define ASP_CMD_MSB       15
`define ASP_CMD_LSB       13
`define ASP_ADDR_MSB      12
`define ASP_ADDR_LSB      8
`define ASP_DATA_MSB      7
`define ASP_CMD_READ      3'h2
`define ASP_CMD_WRITE     3'h4

// ----------------------------------------------------------------------
// Configuration words
// ----------------------------------------------------------------------
`define ASP_REG_ZERO_LO   5'h00
`define ASP_REG_ZERO_HI   5'h01
`define ASP_REG_THRESH    5'h06
`define ASP_REG_ROT       5'h09
`define ASP_ROT_BIT       7
`define ASP_REG_RESET     8'h00
`define ASP_THRESH_RESET  8'h1c

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ASP_CLK_PERIOD_PS 5000
`define ASP_SCLK_MAX_MHZ  25
`define ASP_SCLK_HALF_CYC ((1000000 / (2 * `ASP_SCLK_MAX_MHZ)) / `ASP_CLK_PERIOD_PS)
`define ASP_REFRESH_NS    1000
`define ASP_REFRESH_CYC   ((`ASP_REFRESH_NS * 1000) / `ASP_CLK_PERIOD_PS)
`define ASP_MEM_WAIT_MS   20
`define ASP_MEM_WAIT_CYC  ((`ASP_MEM_WAIT_MS * 1000000) / (`ASP_CLK_PERIOD_PS / 1000))

`endif

// ==== rtl/asp_nvm.sv ====
`timescale 1ns/1ps
`include "asp_defs.svh"
module asp_nvm #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 8
) (
  input  wire logic                     clk_in,
  input  wire logic                     nrst_in,
  input  wire logic                     wr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
  input  wire logic [WIDTH-1:0]         wr_data_in,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
  output logic      [WIDTH-1:0]         rd_data_out
);

  // The array has no reset: its content must survive a reset like the
  // non-volatile cells it stands for. The initial load is the factory state.
  logic [WIDTH-1:0] mem [DEPTH];

  generate
    if (DEPTH < 2 || WIDTH != 8) begin : g_bad_size
      $error("asp_nvm needs DEPTH of at least 2 and WIDTH of 8");
    end
  endgenerate

  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = (i == int'(`ASP_REG_THRESH)) ? `ASP_THRESH_RESET : `ASP_REG_RESET;
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  // Write-first, so a read of the word being committed already sees it.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_out <= '0;
    end else if (wr_en_in && wr_addr_in == rd_addr_in) begin
      rd_data_out <= wr_data_in;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule

// ==== rtl/asp_pkg.sv ====
package asp_pkg;

  typedef enum logic [2:0] {
    st_boot,
    st_ld_zlo,
    st_ld_zhi,
    st_ld_rot,
    st_idle,
    st_wait
  } asp_nvm_state_type;

endpackage

// ==== rtl/asp_spi_slave.sv ====
`timescale 1ns/1ps
`include "asp_defs.svh"
// Functional notes
// - Accept clock modes 0 and 3, detecting the idle clock level by itself.
// - Serial clock up to 25 MHz, no lower limit on rate.
// - Sample on rising edge, shift out on falling edge; select idles high.
// - Load a fresh angle into the output buffer every 1 us when not selected.
// - Select falling freezes the buffer and starts shifting; rising releases it.
// - Full angle takes 16 clocks MSB first; fewer clocks give upper bits.
// - Bit positions beyond the angle resolution are sent as zeros.
// - Fast reads return the same angle until a new one is loaded.
// - Register read: frame with 010, 5-bit address, eight zeros, then reply frame.
// - Reply frame of a read carries the 8-bit value in the upper byte.
// - Register write: frame with 100, 5-bit address, 8-bit value, MSB first.
// - Reply frame of a write returns the stored value, which is the old one until the update ends.
// - No wait is imposed after reads; only writes need the update time.
// - Written values are non-volatile and reloaded into working copies at power-up.
// - Word 9 bit 7 high makes counterclockwise the positive angle direction.
// - Serial output is released while not selected; line pulled low outside.
module asp_spi_slave
  import asp_pkg::*;
#(
  parameter int ANGLE_BITS   = 8,
  parameter int MEM_WAIT_CYC = int'(`ASP_MEM_WAIT_CYC)
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        mosi_in,
  input  wire logic [15:0] angle_raw_in,
  output logic             miso_out,
  output logic             miso_oe_out,
  output logic             rot_ccw_out,
  output logic             nvm_busy_out
);

  // ----------------------------------------------------------------------
  // Constants and checks
  // ----------------------------------------------------------------------
  localparam int          REFRESH_CYC = `ASP_REFRESH_CYC;
  localparam int          WAIT_W      = $clog2(MEM_WAIT_CYC + 1);
  localparam logic [15:0] ANGLE_MASK  = ~(16'hffff >> ANGLE_BITS);

  generate
    if (ANGLE_BITS < 1 || ANGLE_BITS > `ASP_FRAME_BITS) begin : g_bad_bits
      $error("ANGLE_BITS must lie between 1 and the frame length");
    end
    if (MEM_WAIT_CYC < 1) begin : g_bad_wait
      $error("MEM_WAIT_CYC must be at least 1");
    end
    // Each serial clock phase must outlast the synchroniser and edge finder.
    if (`ASP_SCLK_HALF_CYC < 3) begin : g_bad_rate
      $error("System clock too slow for the fastest serial clock");
    end
  endgenerate

  function automatic logic addr_is(input logic [4:0] a, input logic [4:0] b);
    return a == b;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisation and edge finding
  // ----------------------------------------------------------------------
  logic [2:0] pins_s;
  logic       sclk_s;
  logic       cs_s;
  logic       mosi_s;
  logic       sclk_prev_q;
  logic       cs_prev_q;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;

  // Each stage resets to its pin's idle level with the clock low, so reset release shows no edge in mode 0.
  asp_sync #(.WIDTH(3), .RESET_VAL(3'b010)) u_sync (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .async_in ({sclk_in, cs_n_in, mosi_in}),
    .sync_out (pins_s)
  );

  assign sclk_s    = pins_s[2];
  assign cs_s      = pins_s[1];
  assign mosi_s    = pins_s[0];
  assign sclk_rise = sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign cs_fall   = ~cs_s & cs_prev_q;
  assign cs_rise   = cs_s & ~cs_prev_q;

  // Select resets high so reset release shows no select rise; a pin held low then starts a frame.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q   <= cs_s;
    end
  end

  // ----------------------------------------------------------------------
  // Working configuration and memory control
  // ----------------------------------------------------------------------
  asp_nvm_state_type  state_q;
  logic [WAIT_W-1:0]  wait_cnt_q;
  logic [4:0]         wr_addr_q;
  logic [7:0]         wr_data_q;
  logic [4:0]         rd_addr_q;
  logic [4:0]         mem_raddr;
  logic [7:0]         mem_rdata;
  logic               nvm_we;
  logic [15:0]        zero_q;
  logic               rot_q;
  logic               frame_ok;
  logic [2:0]         cmd;
  logic [15:0]        rx_q;

  assign cmd          = rx_q[`ASP_CMD_MSB:`ASP_CMD_LSB];
  assign nvm_we       = state_q == st_wait && wait_cnt_q == WAIT_W'(MEM_WAIT_CYC - 1);
  assign rot_ccw_out  = rot_q;
  assign nvm_busy_out = state_q == st_wait;

  always_comb begin
    case (state_q)
      st_boot:   mem_raddr = `ASP_REG_ZERO_LO;
      st_ld_zlo: mem_raddr = `ASP_REG_ZERO_HI;
      st_ld_zhi: mem_raddr = `ASP_REG_ROT;
      default:   mem_raddr = rd_addr_q;
    endcase
  end

  asp_nvm #(.DEPTH(32), .WIDTH(8)) u_nvm (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .wr_en_in    (nvm_we),
    .wr_addr_in  (wr_addr_q),
    .wr_data_in  (wr_data_q),
    .rd_addr_in  (mem_raddr),
    .rd_data_out (mem_rdata)
  );

  // A write frame starts the update; a second write during it is dropped.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q    <= st_boot;
      wait_cnt_q <= '0;
      wr_addr_q  <= '0;
      wr_data_q  <= '0;
    end else begin
      case (state_q)
        st_boot:   state_q <= st_ld_zlo;
        st_ld_zlo: state_q <= st_ld_zhi;
        st_ld_zhi: state_q <= st_ld_rot;
        st_ld_rot: state_q <= st_idle;
        st_idle: begin
          if (cs_rise && frame_ok && cmd == `ASP_CMD_WRITE) begin
            state_q    <= st_wait;
            wait_cnt_q <= '0;
            wr_addr_q  <= rx_q[`ASP_ADDR_MSB:`ASP_ADDR_LSB];
            wr_data_q  <= rx_q[`ASP_DATA_MSB:0];
          end
        end
        st_wait: begin
          if (nvm_we) begin
            state_q <= st_idle;
          end else begin
            wait_cnt_q <= WAIT_W'(wait_cnt_q + 1'b1);
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // Working copies are filled from memory after each reset and follow commits.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      zero_q <= '0;
      rot_q  <= 1'b0;
    end else if (state_q == st_ld_zlo) begin
      zero_q[7:0] <= mem_rdata;
    end else if (state_q == st_ld_zhi) begin
      zero_q[15:8] <= mem_rdata;
    end else if (state_q == st_ld_rot) begin
      rot_q <= mem_rdata[`ASP_ROT_BIT];
    end else if (nvm_we) begin
      if (addr_is(wr_addr_q, `ASP_REG_ZERO_LO)) begin
        zero_q[7:0] <= wr_data_q;
      end else if (addr_is(wr_addr_q, `ASP_REG_ZERO_HI)) begin
        zero_q[15:8] <= wr_data_q;
      end else if (addr_is(wr_addr_q, `ASP_REG_ROT)) begin
        rot_q <= wr_data_q[`ASP_ROT_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Angle buffer
  // ----------------------------------------------------------------------
  logic [$clog2(REFRESH_CYC)-1:0] ref_cnt_q;
  logic                           ref_tick;
  logic [15:0]                    angle_sum;
  logic [15:0]                    angle_next;
  logic [15:0]                    abuf_q;

  assign ref_tick  = ref_cnt_q == ($clog2(REFRESH_CYC))'(REFRESH_CYC - 1);
  assign angle_sum = 16'(angle_raw_in + zero_q);

  always_comb begin
    angle_next = rot_q ? 16'(16'h0000 - angle_sum) : angle_sum;
    angle_next = angle_next & ANGLE_MASK;
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_cnt_q <= '0;
    end else if (ref_tick) begin
      ref_cnt_q <= '0;
    end else begin
      ref_cnt_q <= ($clog2(REFRESH_CYC))'(ref_cnt_q + 1'b1);
    end
  end

  // A read holds the buffer until select rises again.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      abuf_q <= '0;
    end else if (ref_tick && cs_s) begin
      abuf_q <= angle_next;
    end
  end

  // ----------------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------------
  logic [4:0]  bit_cnt_q;
  logic [15:0] tx_q;
  logic        skip_fall_q;
  logic        pend_q;
  logic        oe_q;

  assign frame_ok    = bit_cnt_q == 5'(`ASP_FRAME_BITS);
  assign miso_out    = tx_q[15];
  assign miso_oe_out = oe_q;

  // An idle-high clock at select fall means mode 3: its first falling edge
  // comes before any data and must not shift.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      skip_fall_q <= 1'b0;
    end else if (cs_fall) begin
      skip_fall_q <= sclk_s;
    end else if (sclk_fall) begin
      skip_fall_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bit_cnt_q <= '0;
      rx_q      <= '0;
    end else if (cs_fall) begin
      bit_cnt_q <= '0;
    end else if (sclk_rise && !cs_s) begin
      rx_q <= {rx_q[14:0], mosi_s};
      if (bit_cnt_q != 5'h1f) begin
        bit_cnt_q <= 5'(bit_cnt_q + 1'b1);
      end
    end
  end

  // Output changes only on falling edges; the pin path adds about three
  // system clocks, which the fastest master timing must absorb.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_q <= '0;
    end else if (cs_fall) begin
      tx_q <= pend_q ? {mem_rdata, 8'h00} : abuf_q;
    end else if (cs_s) begin
      tx_q <= '0;
    end else if (sclk_fall && !skip_fall_q) begin
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  // Register replies are served from memory straight away, no wait needed.
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_q    <= 1'b0;
      rd_addr_q <= '0;
    end else if (cs_fall) begin
      pend_q <= 1'b0;
    end else if (cs_rise) begin
      if (frame_ok && (cmd == `ASP_CMD_READ || cmd == `ASP_CMD_WRITE)) begin
        pend_q    <= 1'b1;
        rd_addr_q <= rx_q[`ASP_ADDR_MSB:`ASP_ADDR_LSB];
      end else begin
        pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= ~cs_s;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  AST_MODE3_SEEN: assert property (
    cs_fall && sclk_s |=> skip_fall_q)
    else $error("Mode 3 idle level not detected");
  AST_MODE3_SKIP: assert property (
    skip_fall_q && sclk_fall && !cs_s && !cs_fall |=> $stable(tx_q))
    else $error("Mode 3 first falling edge not masked");
  AST_SHIFT_ON_FALL: assert property (
    !cs_s && !cs_fall && !sclk_fall |=> $stable(tx_q))
    else $error("Output shifted outside a falling edge");
  AST_FREEZE: assert property (
    !cs_s |=> $stable(abuf_q))
    else $error("Angle buffer changed during a read");
  AST_REFRESH: assert property (
    ref_tick && cs_s |=> abuf_q == $past(angle_next) ##1 !ref_tick [*8])
    else $error("Angle buffer not refreshed on tick");
  AST_PAD_ZERO: assert property (
    (abuf_q & ~ANGLE_MASK) == 16'h0000)
    else $error("Angle padding bits not zero");
  AST_ANGLE_LOAD: assert property (
    cs_fall && !pend_q |=> tx_q == $past(abuf_q))
    else $error("Angle frame did not load the buffer");
  AST_REG_REPLY: assert property (
    cs_fall && pend_q |=> tx_q == {$past(mem_rdata), 8'h00} && !pend_q)
    else $error("Register reply not in upper byte");
  AST_READ_DECODE: assert property (
    cs_rise && frame_ok && cmd == `ASP_CMD_READ
      |=> pend_q && rd_addr_q == $past(rx_q[`ASP_ADDR_MSB:`ASP_ADDR_LSB]))
    else $error("Read request not recognised");
  AST_JUNK_FRAME: assert property (
    cs_rise && cmd != `ASP_CMD_READ && cmd != `ASP_CMD_WRITE |=> !pend_q)
    else $error("Unknown command produced a register reply");
  AST_WRITE_ACK: assert property (
    nvm_we && mem_raddr == wr_addr_q |=> mem_rdata == $past(wr_data_q))
    else $error("Committed value not read back");
  AST_WRITE_WAIT: assert property (
    $rose(state_q == st_wait) |-> !nvm_we [*2] ##1 (wait_cnt_q == WAIT_W'(2)))
    else $error("Memory committed before the update wait");
  AST_ROT_DIR: assert property (
    nvm_we && wr_addr_q == `ASP_REG_ROT |=> rot_q == $past(wr_data_q[`ASP_ROT_BIT]))
    else $error("Rotation direction not updated");
  AST_RELOAD: assert property (
    state_q == st_ld_rot |=> rot_q == $past(mem_rdata[`ASP_ROT_BIT]) && state_q == st_idle)
    else $error("Working copy not reloaded");
  AST_RELEASE: assert property (
    cs_s |=> !miso_oe_out ##1 (cs_s || miso_oe_out || !miso_out))
    else $error("Output driven while not selected");

  COV_MODE3: cover property (cs_fall && sclk_s);
  COV_FULL_FRAME: cover property (cs_rise && frame_ok);
  COV_WRITE_DONE: cover property (nvm_we);
  COV_REG_REPLY: cover property (cs_fall && pend_q);

endmodule

// ==== rtl/asp_sync.sv ====
`timescale 1ns/1ps
module asp_sync #(
  parameter int               WIDTH     = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("asp_sync needs WIDTH of at least 1");
    end
  endgenerate

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_q   <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
